// [common/drv_ctrl_pkg.sv]
/*
 Constants and carrier types for the output control block with its
 serial command link. Assumes a 250 MHz system clock.
*/
`default_nettype none

package drv_ctrl_pkg;
	// Channel count and command word layout.
	localparam int CH           = 4;
	localparam int CMD_W        = 16;
	localparam int CMD_INJ_LSB  = 0;
	localparam int CMD_GATE_LSB = 4;
	localparam int CMD_MODE_LSB = 8;
	localparam int CMD_TEN_BIT  = 12;
	localparam int CMD_FILT_LSB = 13;
	localparam int FILT_W       = 3;
	localparam logic [CMD_W-1:0] CMD_RESET = 16'h0000;
	localparam int BYTE_BITS    = 8;
	localparam int CNT_W        = 6;
	localparam int IDX_W        = 4;

	// Timing, each time in its own unit and then in clock cycles.
	localparam int SYS_CLK_MHZ       = 250;
	localparam int POR_FILTER_NS     = 1000;
	localparam int POR_FILTER_CYCLES =
		(POR_FILTER_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int POR_W             = 10;
	localparam int FAULT_STEP_US     = 30;
	localparam int FAULT_STEP_CYCLES = FAULT_STEP_US * SYS_CLK_MHZ;
	localparam int SPARK_OPEN_US     = 100;
	localparam int SPARK_OPEN_CYCLES = SPARK_OPEN_US * SYS_CLK_MHZ;
	localparam int TMR_W             = 20;

	// Pin inputs that arrive from outside the system clock domain.
	typedef struct packed {
		logic [CH-1:0] injectorParallelIn;
		logic [CH-1:0] gateParallelIn;
		logic [CH-1:0] collectorSenseIn;
		logic [CH-1:0] injectorFault;
		logic          outputDisableN;
		logic          level1Cmp;
		logic          limitCmp;
		logic          level1FlagIn;
		logic          limitFlagIn;
		logic          batterySupply;
		logic          logicSupply;
	} pins_in_t;

	typedef enum logic {PWR_DOWN, PWR_NORMAL} pwr_state_t;
endpackage

`default_nettype wire

// [hdl/driver_output_control_serial_if.sv]
/*
 Serial command link and output control of a four channel driver.
 Assumes a host that idles the serial clock low, changes chip select
 only while the clock is low, and leaves a few system clocks between
 frames. All pin inputs are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module driver_output_control_serial_if #(
	parameter int FAULT_STEP = drv_ctrl_pkg::FAULT_STEP_CYCLES,
	parameter int SPARK_OPEN = drv_ctrl_pkg::SPARK_OPEN_CYCLES
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire logic                    spiClk,
	input  wire logic                    spiCsN,
	input  wire logic                    spiMosi,
	output logic                         spiMiso,
	output logic                         spiMisoEnN,
	input  wire drv_ctrl_pkg::pins_in_t  pinsIn,
	output logic [drv_ctrl_pkg::CH-1:0]  injectorDrive,
	output logic [drv_ctrl_pkg::CH-1:0]  gateDriveOut,
	output logic [drv_ctrl_pkg::CH-1:0]  secondaryClamp,
	output logic                         sparkActiveOut,
	output logic                         sparkActiveEnN,
	output logic                         level1FlagOut,
	output logic                         level1FlagEnN,
	output logic                         limitFlagOut,
	output logic                         limitFlagEnN
);
	localparam int CH = drv_ctrl_pkg::CH;
	localparam int TW = drv_ctrl_pkg::TMR_W;

	typedef struct packed {
		drv_ctrl_pkg::pins_in_t       s1;
		drv_ctrl_pkg::pins_in_t       s2;
		logic                         cs1;
		logic                         cs2;
		logic                         csPrev;
		drv_ctrl_pkg::pwr_state_t     pwr;
		logic [drv_ctrl_pkg::POR_W-1:0] porCnt;
		logic [drv_ctrl_pkg::CMD_W-1:0] cmd;
		logic [drv_ctrl_pkg::CMD_W-1:0] status;
		logic [CH-1:0]                latchOff;
		logic [CH-1:0]                gateFault;
		logic [CH-1:0]                clamp;
		logic [CH-1:0][TW-1:0]        tmr;
		logic [CH-1:0]                inj;
		logic [CH-1:0]                gate;
		logic                         sparkEnN;
		logic                         lvlOut;
		logic                         limOut;
	} sys_t;

	sys_t q;
	sys_t d;

	// Link side state.
	logic [drv_ctrl_pkg::CMD_W-1:0] rxShift;
	logic [drv_ctrl_pkg::CNT_W-1:0] rxCount;
	logic                           newFrame;
	logic [drv_ctrl_pkg::IDX_W-1:0] txIdx;

	// Decoded views of the synchronised pins and the command word.
	drv_ctrl_pkg::pins_in_t p;
	logic [CH-1:0]          gp;
	logic [CH-1:0]          cmdInj;
	logic [CH-1:0]          cmdGate;
	logic                   ten;
	logic                   outputsOn;
	logic                   csRise;
	logic                   frameOk;
	logic [CH-1:0]          limEv;
	logic [TW-1:0]          filtLim;
	logic [TW-1:0]          sparkLim;

	// Bits of the rising serial clock, only while selected.
	always_ff @(posedge spiClk)
	begin
		if (!spiCsN)
		begin
			rxShift <= {rxShift[drv_ctrl_pkg::CMD_W-2:0], spiMosi};
			rxCount <= newFrame ? {{(drv_ctrl_pkg::CNT_W-1){1'b0}}, 1'b1}
				: rxCount + 1'b1;
		end
	end

	// Deselect sets the start marker and the frame's first clock clears it,
	// since the clock stands still between frames and cannot set it.
	always_ff @(posedge spiClk or posedge spiCsN)
	begin
		if (spiCsN)
			newFrame <= 1'b1;
		else
			newFrame <= 1'b0;
	end

	// Output bit index advances on falling clock edges.
	always_ff @(negedge spiClk or posedge spiCsN)
	begin
		if (spiCsN)
			txIdx <= '0;
		else
			txIdx <= txIdx + 1'b1;
	end

	// The status word is frozen in the system domain while selected, so
	// the link side may read it directly without a further crossing.
	assign spiMiso    = q.status[4'hf - txIdx];
	assign spiMisoEnN = spiCsN;

	// Decoding shared by the next-state logic and the checks.
	assign p         = q.s2;
	assign gp        = q.cmd[drv_ctrl_pkg::CMD_MODE_LSB +: CH];
	assign cmdInj    = q.cmd[drv_ctrl_pkg::CMD_INJ_LSB +: CH];
	assign cmdGate   = q.cmd[drv_ctrl_pkg::CMD_GATE_LSB +: CH];
	assign ten       = q.cmd[drv_ctrl_pkg::CMD_TEN_BIT];
	assign outputsOn = (q.pwr == drv_ctrl_pkg::PWR_NORMAL)
		&& !p.outputDisableN;
	assign csRise    = q.cs2 && !q.csPrev;
	// Count and shift are stable here: the clock idles while deselected.
	assign frameOk   = (rxCount[2:0] == 3'h0) && (rxCount != '0);
	assign filtLim   = TW'((int'(q.cmd[drv_ctrl_pkg::CMD_FILT_LSB +:
		drv_ctrl_pkg::FILT_W]) + 1) * FAULT_STEP);
	assign sparkLim  = TW'(SPARK_OPEN);

	// Limit events per gate; in ten cylinder mode the flag pins are
	// inputs, the limit pin for even gates and the level pin for odd.
	generate
		for (genvar g = 0; g < CH; g++)
		begin : gLim
			if (g % 2 == 0)
			begin : gEven
				assign limEv[g] = ten ? p.limitFlagIn : p.limitCmp;
			end
			else
			begin : gOdd
				assign limEv[g] = ten ? p.level1FlagIn : p.limitCmp;
			end
		end
	endgenerate

	// Next state of the system domain.
	always_comb
	begin
		logic abn;
		logic hit;
		logic [TW-1:0] lim;
		logic [CH-1:0] gateDem;
		abn     = 1'b0;
		hit     = 1'b0;
		lim     = '0;
		gateDem = '0;
		d       = q;
		d.s1     = pinsIn;
		d.s2     = q.s1;
		d.cs1    = spiCsN;
		d.cs2    = q.cs1;
		d.csPrev = q.cs2;

		// Supply qualification: a change must persist for the filter time.
		if ((p.batterySupply && p.logicSupply)
			== (q.pwr == drv_ctrl_pkg::PWR_NORMAL))
			d.porCnt = '0;
		else if (q.porCnt == drv_ctrl_pkg::POR_W'(
			drv_ctrl_pkg::POR_FILTER_CYCLES - 1))
		begin
			d.porCnt = '0;
			case (q.pwr)
				drv_ctrl_pkg::PWR_DOWN:   d.pwr = drv_ctrl_pkg::PWR_NORMAL;
				drv_ctrl_pkg::PWR_NORMAL: d.pwr = drv_ctrl_pkg::PWR_DOWN;
				default:                  d.pwr = drv_ctrl_pkg::PWR_DOWN;
			endcase
		end
		else
			d.porCnt = q.porCnt + 1'b1;

		// Commit a whole frame on the select rise, whatever the disable.
		if (csRise && frameOk)
			d.cmd = rxShift;

		// Status snapshot follows live faults only while deselected.
		if (q.cs2)
			d.status = {{(drv_ctrl_pkg::CMD_W-2*CH){1'b0}},
				q.gateFault, p.injectorFault};

		// Fault flags clear once reported; a new fault below wins.
		if (csRise)
			d.gateFault = '0;

		for (int i = 0; i < CH; i++)
		begin
			// Dropping the whole demand, parallel or command, releases a
			// latch-off. Releasing on the parallel input alone would let a
			// command driven general gate retry a short every cycle.
			if (!(p.gateParallelIn[i] || (gp[i] && cmdGate[i])))
				d.latchOff[i] = 1'b0;
			if (!gp[i] && limEv[i] && p.gateParallelIn[i])
				d.latchOff[i] = 1'b1;

			// One timer per gate, its meaning chosen by the gate mode.
			if (gp[i])
			begin
				abn = q.gate[i] ? p.collectorSenseIn[i]
					: !p.collectorSenseIn[i];
				lim = filtLim;
			end
			else
			begin
				abn = !q.gate[i] && p.collectorSenseIn[i];
				lim = sparkLim;
			end
			hit = abn && (q.tmr[i] >= lim);
			if (!abn)
				d.tmr[i] = '0;
			else if (!hit)
				d.tmr[i] = q.tmr[i] + 1'b1;
			if (gp[i] && hit)
			begin
				d.gateFault[i] = 1'b1;
				if (q.gate[i])
					d.latchOff[i] = 1'b1;
			end
			d.clamp[i] = !gp[i] && hit;
		end

		// Output demand: general gates and injectors OR in the command.
		for (int i = 0; i < CH; i++)
		begin
			gateDem[i] = (p.gateParallelIn[i] || (gp[i] && cmdGate[i]))
				&& !q.latchOff[i];
		end
		d.inj  = outputsOn ? (p.injectorParallelIn | cmdInj) : '0;
		d.gate = outputsOn ? gateDem : '0;

		// Flags and the open drain spark output.
		d.sparkEnN = !(|p.collectorSenseIn);
		d.lvlOut   = p.level1Cmp;
		d.limOut   = p.limitCmp;

		// Without qualified supplies the command, faults, timers and drives return to reset values.
		if (q.pwr == drv_ctrl_pkg::PWR_DOWN)
		begin
			d.cmd       = drv_ctrl_pkg::CMD_RESET;
			d.latchOff  = '0;
			d.gateFault = '0;
			d.clamp     = '0;
			d.tmr       = '0;
			d.inj       = '0;
			d.gate      = '0;
		end
	end

	// Register the system state; select idles high out of reset.
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			q        <= '0;
			q.cs1    <= 1'b1;
			q.cs2    <= 1'b1;
			q.csPrev <= 1'b1;
			q.pwr    <= drv_ctrl_pkg::PWR_DOWN;
			q.sparkEnN <= 1'b1;
		end
		else
			q <= d;
	end

	// Outputs straight from the state.
	assign injectorDrive  = q.inj;
	assign gateDriveOut   = q.gate;
	assign secondaryClamp = q.clamp;
	assign sparkActiveOut = 1'b0;
	assign sparkActiveEnN = q.sparkEnN;
	assign level1FlagOut  = q.lvlOut;
	assign level1FlagEnN  = ten;
	assign limitFlagOut   = q.limOut;
	assign limitFlagEnN   = ten;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	outputs_off_a: assert property (
		p.outputDisableN |=> (injectorDrive == '0) && (gateDriveOut == '0))
		else $error("outputs on while disabled");

	inj_or_a: assert property (
		outputsOn |=> injectorDrive == $past(p.injectorParallelIn | cmdInj))
		else $error("injector drive not input OR command");

	ign_follow_a: assert property (
		outputsOn && !gp[0] && !q.latchOff[0]
		|=> gateDriveOut[0] == $past(p.gateParallelIn[0]))
		else $error("ignition gate not following its input");

	commit_a: assert property (
		csRise && frameOk && (q.pwr == drv_ctrl_pkg::PWR_NORMAL)
		|=> q.cmd == $past(rxShift))
		else $error("frame not committed");

	discard_a: assert property (
		csRise && !frameOk && (q.pwr == drv_ctrl_pkg::PWR_NORMAL)
		|=> $stable(q.cmd))
		else $error("partial frame changed command");

	spark_low_a: assert property (
		(|p.collectorSenseIn) |=> !sparkActiveEnN)
		else $error("spark output not driven low");

	limit_latch_a: assert property (
		!ten && p.limitCmp && !gp[0] && p.gateParallelIn[0]
		&& (q.pwr == drv_ctrl_pkg::PWR_NORMAL)
		|=> ##1 !gateDriveOut[0])
		else $error("limit did not latch gate off");

	ten_latch_a: assert property (
		ten && p.level1FlagIn && !gp[1] && p.gateParallelIn[1]
		&& (q.pwr == drv_ctrl_pkg::PWR_NORMAL)
		|=> ##1 !gateDriveOut[1])
		else $error("level pin did not latch gate off");

	level_flag_a: assert property (
		!ten && p.level1Cmp |=> level1FlagOut && !level1FlagEnN)
		else $error("level flag not raised");

	status_hold_a: assert property (
		!q.cs2 && !q.csPrev |=> $stable(q.status))
		else $error("status changed inside a frame");

	power_down_a: assert property (
		q.pwr == drv_ctrl_pkg::PWR_DOWN
		|=> (injectorDrive == '0) && (q.cmd == drv_ctrl_pkg::CMD_RESET))
		else $error("outputs alive without supplies");

	short_latch_a: assert property (
		gp[0] && q.gate[0] && p.collectorSenseIn[0]
		&& (q.tmr[0] >= filtLim) && (q.pwr == drv_ctrl_pkg::PWR_NORMAL)
		|=> ##1 !gateDriveOut[0])
		else $error("short did not latch gate off");

	open_fault_a: assert property (
		gp[0] && !q.gate[0] && !p.collectorSenseIn[0]
		&& (q.tmr[0] >= filtLim) && (q.pwr == drv_ctrl_pkg::PWR_NORMAL)
		|=> q.gateFault[0])
		else $error("open load not flagged");

	clamp_set_a: assert property (
		!gp[2] && !q.gate[2] && p.collectorSenseIn[2]
		&& (q.tmr[2] >= sparkLim) && (q.pwr == drv_ctrl_pkg::PWR_NORMAL)
		|=> secondaryClamp[2])
		else $error("secondary clamp not raised");
endmodule

`default_nettype wire

// [tb/driver_output_control_serial_if_tb.sv]
/*
 Self-checking bench for the output control block.
 Assumes the host model in tb/host_model.sv drives the link.
*/
`timescale 1ns/1ps
`default_nettype none

module driver_output_control_serial_if_tb;
	logic                    sysClk;
	logic                    rst;
	logic                    spiClk;
	logic                    spiCsN;
	logic                    spiMosi;
	logic                    spiMiso;
	logic                    spiMisoEnN;
	drv_ctrl_pkg::pins_in_t  pins;
	logic [3:0]              inj;
	logic [3:0]              gate;
	logic                    sparkEnN;
	logic                    l1Out;
	logic                    l1EnN;
	logic                    limOut;
	logic                    limEnN;
	logic                    sparkOut;
	logic [3:0]              clamp;
	logic [15:0]             rx;
	int                      nMismatch;
	int                      nCompared;
	int                      cycles;

	// Short filter counts keep the run brief.
	driver_output_control_serial_if #(.FAULT_STEP(8), .SPARK_OPEN(8)) i_dut (
		.sys_clk(sysClk), .rst(rst), .spiClk(spiClk), .spiCsN(spiCsN),
		.spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoEnN(spiMisoEnN),
		.pinsIn(pins), .injectorDrive(inj), .gateDriveOut(gate),
		.secondaryClamp(clamp), .sparkActiveOut(sparkOut),
		.sparkActiveEnN(sparkEnN), .level1FlagOut(l1Out),
		.level1FlagEnN(l1EnN), .limitFlagOut(limOut),
		.limitFlagEnN(limEnN));

	host_model i_host (.spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
		.spiMiso(spiMiso), .spiMisoEnN(spiMisoEnN));

	// System clock, 4 ns period.
	initial
	begin
		sysClk = 1'b0;
		forever #2 sysClk = ~sysClk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		nCompared++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Waiting past the edge lets registered outputs settle first.
	task automatic wt(input int n);
		repeat (n) @(posedge sysClk);
		#1;
	endtask

	task automatic send(input logic [15:0] cmd, input int n);
		i_host.frame(cmd, n, rx);
		wt(10);
	endtask

	task closeOut;
		if (nMismatch == 0 && nCompared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// A hang counts as a mismatch and ends the run.
	always @(posedge sysClk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			nMismatch++;
			closeOut();
		end
	end

	task automatic t_power;
		wt(300);
		chk(16'(spiMisoEnN), 16'h0001);
		chk(16'({inj, gate}), 16'h0000);
		chk(16'({l1EnN, limEnN}), 16'h0000);
	endtask

	task automatic t_status;
		@(posedge sysClk) pins.injectorFault <= 4'h5;
		wt(6);
		send(16'h000f, 16);
		chk(rx, 16'h0005);
		chk(16'(inj), 16'h000f);
		send(16'h0000, 12);
		chk(16'(inj), 16'h000f);
	endtask

	task automatic t_disable;
		@(posedge sysClk) pins.outputDisableN <= 1'b1;
		wt(6);
		chk(16'(inj), 16'h0000);
		send(16'h0003, 16);
		chk(16'(inj), 16'h0000);
		@(posedge sysClk) pins.outputDisableN <= 1'b0;
		wt(6);
		chk(16'(inj), 16'h0003);
	endtask

	task automatic t_gate;
		send(16'h00f0, 16);
		chk(16'(gate), 16'h0000);
		send(16'h0ff0, 16);
		chk(16'(gate), 16'h000f);
		send(16'h0000, 16);
	endtask

	task automatic t_limit;
		@(posedge sysClk) pins.gateParallelIn <= 4'h1;
		wt(6);
		chk(16'(gate), 16'h0001);
		@(posedge sysClk) pins.limitCmp <= 1'b1;
		pins.level1Cmp <= 1'b1;
		wt(6);
		chk(16'({limOut, l1Out, gate}), 16'h0030);
		@(posedge sysClk) pins.limitCmp <= 1'b0;
		pins.level1Cmp <= 1'b0;
		wt(6);
		chk(16'({l1Out, gate}), 16'h0000);
		@(posedge sysClk) pins.gateParallelIn <= 4'h0;
		wt(6);
	endtask

	// The open-drain spark pin only ever pulls low.
	task automatic t_spark;
		@(posedge sysClk) pins.collectorSenseIn <= 4'h4;
		wt(6);
		chk(16'({sparkOut, sparkEnN}), 16'h0000);
		wt(10);
		chk(16'(clamp), 16'h0004);
		@(posedge sysClk) pins.collectorSenseIn <= 4'h0;
		wt(6);
		chk(16'(sparkEnN), 16'h0001);
		chk(16'(clamp), 16'h0000);
	endtask

	// General gate 0 on by command; a short latches it off and the
	// fault shows in the next status word.
	task automatic t_fault;
		send(16'h0110, 16);
		chk(16'(gate), 16'h0001);
		@(posedge sysClk) pins.collectorSenseIn <= 4'h1;
		wt(20);
		chk(16'(gate), 16'h0000);
		@(posedge sysClk) pins.collectorSenseIn <= 4'h0;
		wt(6);
		chk(16'(gate), 16'h0000);
		send(16'h0110, 16);
		chk(rx, 16'h0015);
		send(16'h0000, 16);
		chk(16'(gate), 16'h0000);
	endtask

	task automatic t_ten;
		send(16'h1000, 16);
		chk(16'({l1EnN, limEnN}), 16'h0003);
		@(posedge sysClk) pins.gateParallelIn <= 4'h3;
		pins.limitFlagIn <= 1'b1;
		wt(6);
		chk(16'(gate), 16'h0002);
		@(posedge sysClk) pins.level1FlagIn <= 1'b1;
		wt(6);
		chk(16'(gate), 16'h0000);
	endtask

	// Supplies present from the start; reset held ten cycles.
	initial
	begin
		nMismatch = 0;
		nCompared = 0;
		cycles = 0;
		pins = '0;
		pins.batterySupply = 1'b1;
		pins.logicSupply = 1'b1;
		rst = 1'b1;
		repeat (10) @(posedge sysClk);
		rst <= 1'b0;
		t_power();
		t_status();
		t_disable();
		t_gate();
		t_limit();
		t_spark();
		t_fault();
		t_ten();
		closeOut();
	end
endmodule

`default_nettype wire

// [tb/host_model.sv]
/*
 Behavioural host for the serial command link.
 Assumes the bench calls frame() from one process at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module host_model (
	output var logic spiClk,
	output var logic spiCsN,
	output var logic spiMosi,
	input  wire logic spiMiso,
	input  wire logic spiMisoEnN
);
	// Clock idles low and select high between frames. A defined rising
	// select edge at the start clears the bit index and sets the start
	// marker, which have no other reset.
	initial
	begin
		spiClk = 1'b0;
		spiCsN = 1'b0;
		spiMosi = 1'b0;
		#1 spiCsN = 1'b1;
	end

	// One frame, most significant bit first, 64 ns link clock.
	task automatic frame(input logic [15:0] tx, input int n,
		output logic [15:0] rx);
		rx = 16'h0000;
		// The odd delay keeps link edges off the system clock edges.
		#7.3 spiCsN = 1'b0;
		#40;
		for (int i = n - 1; i >= 0; i--)
		begin
			spiMosi = tx[i];
			#32 spiClk = 1'b1;
			rx = {rx[14:0], spiMiso};
			#32 spiClk = 1'b0;
		end
		#40 spiCsN = 1'b1;
		// The released data line must not keep its last value.
		spiMosi = ~spiMosi;
		#1000;
	endtask
endmodule

`default_nettype wire
